/* logic/cfg_regs_pkg.sv */
// Constants, field layouts and carrier types of the stream, auxiliary and receiver config bank
package cfg_regs_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] STREAM_MODE_IDX = 8'h08;
  localparam logic [7:0] AUX_DEF_IDX     = 8'h09;
  localparam logic [7:0] RX_CONF1_IDX    = 8'h0A;
  localparam logic [7:0] CFG_STATUS_IDX  = 8'h3F;
  localparam logic [9:0] STREAM_MODE_ADR = {STREAM_MODE_IDX, 2'b00};
  localparam logic [9:0] AUX_DEF_ADR     = {AUX_DEF_IDX, 2'b00};
  localparam logic [9:0] RX_CONF1_ADR    = {RX_CONF1_IDX, 2'b00};
  localparam logic [9:0] CFG_STATUS_ADR  = {CFG_STATUS_IDX, 2'b00};

  // ****************************************************************
  // Values after reset and the stream write mask
  // ****************************************************************
  localparam logic [7:0] STREAM_MODE_RST = 8'h00;
  localparam logic [7:0] AUX_DEF_RST     = 8'h04;
  localparam logic [7:0] RX_CONF1_RST    = 8'h00;
  localparam logic [7:0] STREAM_MODE_WMASK = 8'h7F;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SCF_LSB = 5;
  localparam int SCP_LSB = 3;
  localparam int STX_LSB = 0;
  localparam int NO_CRC_RX_BIT  = 7;
  localparam int CRC_FIFO_BIT   = 6;
  localparam int MOD_AM_BIT     = 5;
  localparam int FD_EN_BIT      = 4;
  localparam int OOK_TRI_BIT    = 3;
  localparam int RX_TOL_BIT     = 2;
  localparam int NFC_N_LSB      = 0;
  localparam int RECEIVE_CHANNEL_SELECT_BIT     = 7;
  localparam int AMD_SEL_BIT    = 6;
  localparam int LP_LSB         = 3;
  localparam int ZERO_LSB       = 0;

  // ****************************************************************
  // Divider bases in fc cycles and unused divider codes
  // ****************************************************************
  localparam logic [6:0] SUBC_BASE_DIV = 7'h40;
  localparam logic [6:0] BPSK_BASE_DIV = 7'h10;
  localparam logic [7:0] TX_BASE_DIV   = 8'h80;
  localparam logic [1:0] BPSK_UNUSED   = 2'b11;
  localparam logic [2:0] TX_UNUSED     = 3'b111;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [6:0] subcarrier_div;
    logic [3:0] report_pulses;
    logic [7:0] tx_period_div;
  } stream_ctrl_t;

  typedef struct packed {
    logic       rx_crc_expected;
    logic       crc_to_fifo;
    logic       modulation_type_sel;
    logic       field_detector_enable;
    logic       rf_output_driver_tristate;
    logic       rx_tolerant;
    logic [1:0] field_on_count;
  } aux_ctrl_t;

  typedef struct packed {
    logic       am_channel_enable;
    logic       pm_channel_enable;
    logic       framing_from_pm;
    logic       am_demod_mixer;
    logic [2:0] lowpass_ctrl;
    logic [2:0] stage_zero;
  } rx_ctrl_t;

endpackage : cfg_regs_pkg

/* logic/rf_stream_aux_rx_config_regs.sv */
// Wishbone register bank for stream, auxiliary and receiver configuration
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
module rf_stream_aux_rx_config_regs (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire cfg_regs_pkg::wb_req_t      wb_req,
  output logic                            wb_ack_o,
  output logic [31:0]                     wb_dat_o,
  input  wire logic                       set_default_cmd,
  input  wire logic                       analog_preset_cmd,
  input  wire logic                       analog_preset_am,
  input  wire logic                       bpsk_stream_mode,
  input  wire logic                       reqa_wupa_tx,
  input  wire logic                       anticollision_active,
  input  wire logic                       ook_modulating,
  input  wire logic                       rx_single_channel,
  input  wire logic                       manual_channel_sel,
  input  wire logic                       auto_channel_pm,
  output cfg_regs_pkg::stream_ctrl_t      stream_ctrl,
  output cfg_regs_pkg::aux_ctrl_t         aux_ctrl,
  output cfg_regs_pkg::rx_ctrl_t          rx_ctrl
);
  import cfg_regs_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0]   stream_mode_reg;
  logic [7:0]   stream_mode_next;
  logic [7:0]   aux_def_reg;
  logic [7:0]   aux_def_next;
  logic [7:0]   rx_conf1_reg;
  logic [7:0]   rx_conf1_next;
  logic         ack_reg;
  logic         ack_next;
  logic [31:0]  rdata_reg;
  logic [31:0]  rdata_next;
  stream_ctrl_t stream_reg;
  stream_ctrl_t stream_next;
  aux_ctrl_t    aux_reg;
  aux_ctrl_t    aux_next;
  rx_ctrl_t     rxc_reg;
  rx_ctrl_t     rxc_next;
  logic [3:0]   status_reg;
  logic [3:0]   status_next;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic         req_live;
  logic         wr_commit;
  logic         lane0;
  logic [1:0]   scf;
  logic [1:0]   scp;
  logic [2:0]   stx;

  // A request is live while both cyc and stb are high
  assign req_live  = wb_req.cyc & wb_req.stb;
  // Writes land on the edge that samples ack, as the master expects
  assign wr_commit = req_live & wb_req.we & ack_reg;
  // Only byte lane 0 carries register bits
  assign lane0     = wb_req.sel[0];

  // Field slices of the stream register
  assign scf = stream_mode_reg[SCF_LSB +: 2];
  assign scp = stream_mode_reg[SCP_LSB +: 2];
  assign stx = stream_mode_reg[STX_LSB +: 3];

  // ****************************************************************
  // Wishbone answer
  // ****************************************************************

  // Ack one cycle after the request, then drop for one cycle
  always_comb begin
    ack_next   = req_live & ~ack_reg;
    rdata_next = rdata_reg;
    if (req_live && !ack_reg) begin
      rdata_next = 32'h0000_0000; // Unmapped reads return zero
      case (wb_req.adr)
        STREAM_MODE_ADR: begin
          rdata_next[7:0] = stream_mode_reg;
        end
        AUX_DEF_ADR: begin
          rdata_next[7:0] = aux_def_reg;
        end
        RX_CONF1_ADR: begin
          rdata_next[7:0] = rx_conf1_reg;
        end
        CFG_STATUS_ADR: begin
          rdata_next[3:0] = status_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  // Set-default has top priority; a bus write beats the analog preset
  // so software can still override the preset modulation type
  always_comb begin
    stream_mode_next = stream_mode_reg;
    aux_def_next     = aux_def_reg;
    rx_conf1_next    = rx_conf1_reg;
    if (analog_preset_cmd) begin
      aux_def_next[MOD_AM_BIT] = analog_preset_am;
    end
    if (wr_commit && lane0) begin
      case (wb_req.adr)
        STREAM_MODE_ADR: begin
          stream_mode_next = wb_req.dat[7:0] & STREAM_MODE_WMASK;
        end
        AUX_DEF_ADR: begin
          aux_def_next = wb_req.dat[7:0];
        end
        RX_CONF1_ADR: begin
          rx_conf1_next = wb_req.dat[7:0];
        end
        default: begin
          stream_mode_next = stream_mode_reg; // Unmapped write ignored
        end
      endcase
    end
    if (set_default_cmd) begin
      stream_mode_next = STREAM_MODE_RST;
      aux_def_next     = AUX_DEF_RST;
      rx_conf1_next    = RX_CONF1_RST;
    end
  end

  // Power-up defaults come through the asynchronous reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stream_mode_reg <= STREAM_MODE_RST;
      aux_def_reg     <= AUX_DEF_RST;
      rx_conf1_reg    <= RX_CONF1_RST;
    end else begin
      stream_mode_reg <= stream_mode_next;
      aux_def_reg     <= aux_def_next;
      rx_conf1_reg    <= rx_conf1_next;
    end
  end

  // ****************************************************************
  // Stream mode decode
  // ****************************************************************

  // Dividers are counts of fc cycles; unused codes give zero,
  // which stops the stream engine rather than guessing a rate
  always_comb begin
    stream_next = stream_reg;
    if (bpsk_stream_mode) begin
      if (scf == BPSK_UNUSED) begin
        stream_next.subcarrier_div = 7'h00;
      end else begin
        stream_next.subcarrier_div = BPSK_BASE_DIV >> scf;
      end
    end else begin
      stream_next.subcarrier_div = SUBC_BASE_DIV >> scf;
    end
    stream_next.report_pulses = 4'h1 << scp;
    if (stx == TX_UNUSED) begin
      stream_next.tx_period_div = 8'h00;
    end else begin
      stream_next.tx_period_div = TX_BASE_DIV >> stx;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stream_reg <= '0;
    end else begin
      stream_reg <= stream_next;
    end
  end

  // ****************************************************************
  // Auxiliary decode
  // ****************************************************************

  // CRC is expected unless software or an auto-no-CRC case says not
  always_comb begin
    aux_next = aux_reg;
    aux_next.rx_crc_expected = ~(aux_def_reg[NO_CRC_RX_BIT]
                                 | reqa_wupa_tx
                                 | anticollision_active);
    aux_next.crc_to_fifo = aux_def_reg[CRC_FIFO_BIT];
    aux_next.modulation_type_sel = aux_def_reg[MOD_AM_BIT];
    aux_next.field_detector_enable = aux_def_reg[FD_EN_BIT];
    // Tristate only while OOK is both selected and active
    aux_next.rf_output_driver_tristate = aux_def_reg[OOK_TRI_BIT]
                                         & ~aux_def_reg[MOD_AM_BIT]
                                         & ook_modulating;
    aux_next.rx_tolerant = aux_def_reg[RX_TOL_BIT];
    aux_next.field_on_count = aux_def_reg[NFC_N_LSB +: 2];
  end

  // Reset image matches the register defaults, tolerance on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aux_reg <= '{rx_crc_expected: 1'b1, crc_to_fifo: 1'b0,
                   modulation_type_sel: 1'b0, field_detector_enable: 1'b0,
                   rf_output_driver_tristate: 1'b0, rx_tolerant: 1'b1,
                   field_on_count: 2'b00};
    end else begin
      aux_reg <= aux_next;
    end
  end

  // ****************************************************************
  // Receiver decode
  // ****************************************************************

  // Single channel: select bit enables one; dual: both stay on
  always_comb begin
    rxc_next = rxc_reg;
    if (rx_single_channel) begin
      rxc_next.am_channel_enable = ~rx_conf1_reg[RECEIVE_CHANNEL_SELECT_BIT];
      rxc_next.pm_channel_enable = rx_conf1_reg[RECEIVE_CHANNEL_SELECT_BIT];
      rxc_next.framing_from_pm   = rx_conf1_reg[RECEIVE_CHANNEL_SELECT_BIT];
    end else begin
      rxc_next.am_channel_enable = 1'b1;
      rxc_next.pm_channel_enable = 1'b1;
      if (manual_channel_sel) begin
        rxc_next.framing_from_pm = rx_conf1_reg[RECEIVE_CHANNEL_SELECT_BIT];
      end else begin
        rxc_next.framing_from_pm = auto_channel_pm;
      end
    end
    rxc_next.am_demod_mixer = rx_conf1_reg[AMD_SEL_BIT];
    rxc_next.lowpass_ctrl   = rx_conf1_reg[LP_LSB +: 3];
    rxc_next.stage_zero     = rx_conf1_reg[ZERO_LSB +: 3];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxc_reg <= '0;
    end else begin
      rxc_reg <= rxc_next;
    end
  end

  // ****************************************************************
  // Status register
  // ****************************************************************

  // Bit0 CRC expected, bit1 bad BPSK code, bit2 bad Tx code,
  // bit3 one-pulse count outside BPSK mode
  always_comb begin
    status_next    = status_reg;
    status_next[0] = aux_next.rx_crc_expected;
    status_next[1] = bpsk_stream_mode & (scf == BPSK_UNUSED);
    status_next[2] = (stx == TX_UNUSED);
    status_next[3] = ~bpsk_stream_mode & (scp == 2'b00);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_reg <= 4'h1;
    end else begin
      status_reg <= status_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = rdata_reg;
  assign stream_ctrl = stream_reg;
  assign aux_ctrl    = aux_reg;
  assign rx_ctrl     = rxc_reg;

endmodule : rf_stream_aux_rx_config_regs

/* verif/cfg_regs_sva.sv */
// Assertions on the ports of the config register bank
`timescale 1ns/100ps
module cfg_regs_sva import cfg_regs_pkg::*; (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire cfg_regs_pkg::wb_req_t  wb_req,
  input wire logic                   wb_ack_o,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   set_default_cmd,
  input wire logic                   analog_preset_cmd,
  input wire logic                   analog_preset_am,
  input wire logic                   reqa_wupa_tx,
  input wire logic                   anticollision_active,
  input wire logic                   ook_modulating,
  input wire logic                   rx_single_channel,
  input wire cfg_regs_pkg::stream_ctrl_t stream_ctrl,
  input wire cfg_regs_pkg::aux_ctrl_t    aux_ctrl,
  input wire cfg_regs_pkg::rx_ctrl_t     rx_ctrl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Aux write first seen, then acked
  sequence aux_write_s;
    wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack_o && wb_req.sel[0]
      && wb_req.adr == AUX_DEF_ADR ##1 wb_ack_o;
  endsequence
  AST_ACK_ONE_CYCLE: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  AST_ACK_SINGLE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DEFAULTS_RESTORE: assert property (set_default_cmd && !wb_req.cyc |-> ##2
    (aux_ctrl.rx_tolerant && aux_ctrl.field_on_count == 2'h0 && !aux_ctrl.crc_to_fifo
     && stream_ctrl.tx_period_div == 8'h80 && rx_ctrl.lowpass_ctrl == 3'h0))
    else $error("defaults not restored");
  AST_CRC_AUTO: assert property (reqa_wupa_tx || anticollision_active
    |=> !aux_ctrl.rx_crc_expected) else $error("crc expected during auto command");
  AST_TRISTATE_OOK: assert property (aux_ctrl.rf_output_driver_tristate
    |-> !aux_ctrl.modulation_type_sel && $past(ook_modulating)) else $error("bad tristate");
  AST_SINGLE_CHANNEL: assert property ($past(rx_single_channel) && !$past(rst)
    |-> rx_ctrl.am_channel_enable != rx_ctrl.pm_channel_enable) else $error("channel enables");
  AST_PULSES_LEGAL: assert property (!$past(rst) |-> $onehot(stream_ctrl.report_pulses))
    else $error("pulse count not a power of two");
  AST_FIELD_COUNT: assert property (aux_write_s |-> ##2
    aux_ctrl.field_on_count == $past(wb_req.dat[1:0], 3)) else $error("field count");
  AST_PRESET_AM: assert property (analog_preset_cmd && !set_default_cmd && !wb_req.cyc
    |-> ##2 aux_ctrl.modulation_type_sel == $past(analog_preset_am, 2)) else $error("preset");
  AST_STREAM_BIT7: assert property (wb_ack_o && !wb_req.we && wb_req.adr == STREAM_MODE_ADR
    |-> !wb_dat_o[7]) else $error("stream bit seven reads one");
endmodule : cfg_regs_sva

bind rf_stream_aux_rx_config_regs cfg_regs_sva chk_u (
  .core_clk(core_clk), .rst(rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .set_default_cmd(set_default_cmd), .analog_preset_cmd(analog_preset_cmd),
  .analog_preset_am(analog_preset_am), .reqa_wupa_tx(reqa_wupa_tx),
  .anticollision_active(anticollision_active), .ook_modulating(ook_modulating),
  .rx_single_channel(rx_single_channel), .stream_ctrl(stream_ctrl), .aux_ctrl(aux_ctrl),
  .rx_ctrl(rx_ctrl)
);

/* verif/tb_top.sv */
// Self-checking bench for the config register bank
`timescale 1ns/100ps
module tb_top;
  import cfg_regs_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  wb_req_t      wb_req = '0;
  logic         wb_ack_o;
  logic [31:0]  wb_dat_o;
  logic         set_default_cmd = 1'b0;
  logic         analog_preset_cmd = 1'b0;
  logic         analog_preset_am = 1'b0;
  logic         bpsk_stream_mode = 1'b0;
  logic         reqa_wupa_tx = 1'b0;
  logic         anticollision_active = 1'b0;
  logic         ook_modulating = 1'b0;
  logic         rx_single_channel = 1'b1;
  logic         manual_channel_sel = 1'b0;
  logic         auto_channel_pm = 1'b1;
  stream_ctrl_t stream_ctrl;
  aux_ctrl_t    aux_ctrl;
  rx_ctrl_t     rx_ctrl;
  int           mismatches = 0;
  int           n_compared = 0;
  int           cycles = 0;

  rf_stream_aux_rx_config_regs dut_u (
    .core_clk(core_clk), .rst(rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .set_default_cmd(set_default_cmd), .analog_preset_cmd(analog_preset_cmd),
    .analog_preset_am(analog_preset_am), .bpsk_stream_mode(bpsk_stream_mode),
    .reqa_wupa_tx(reqa_wupa_tx), .anticollision_active(anticollision_active),
    .ook_modulating(ook_modulating), .rx_single_channel(rx_single_channel),
    .manual_channel_sel(manual_channel_sel), .auto_channel_pm(auto_channel_pm),
    .stream_ctrl(stream_ctrl), .aux_ctrl(aux_ctrl), .rx_ctrl(rx_ctrl)
  );

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // Cycle ceiling, far above the roughly 170 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("timeout reached");
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic xfer(input logic we, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h000000, d}};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge core_clk);
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, {24'h000000, exp}, {24'h000000, q});
  endtask : rd

  // Main sequence
  initial begin
    logic [7:0] v;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd("stream_rst", STREAM_MODE_ADR, 8'h00);
    rd("aux_rst", AUX_DEF_ADR, 8'h04);
    rd("rx_rst", RX_CONF1_ADR, 8'h00);
    rd("unmapped", 10'h030, 8'h00);
    $display("test reset done");
    // Mode from bit 2 so every frequency code is seen in both modes
    for (int i = 0; i < 8; i++) begin
      bpsk_stream_mode <= i[2];
      v = {1'b1, i[1:0], i[1:0], i[2:0]};
      wr(STREAM_MODE_ADR, v);
      rd("stream_rb", STREAM_MODE_ADR, v & 8'h7F);
      rd("status", CFG_STATUS_ADR, {4'h0, i == 0, i == 7, i == 7, 1'b1});
      chk("subc", i[2] ? (i[1:0] == 2'h3 ? 0 : 16 >> i[1:0]) : 64 >> i[1:0],
          stream_ctrl.subcarrier_div);
      chk("pulses", 1 << i[1:0], stream_ctrl.report_pulses);
      chk("txdiv", i == 7 ? 0 : 128 >> i, stream_ctrl.tx_period_div);
    end
    $display("test stream done");
    ook_modulating <= 1'b1;
    wr(AUX_DEF_ADR, 8'h6B);
    rd("aux_rb", AUX_DEF_ADR, 8'h6B);
    chk("aux_am", 8'hE3, aux_ctrl);
    wr(AUX_DEF_ADR, 8'h98);
    rd("aux_rb", AUX_DEF_ADR, 8'h98);
    chk("aux_ook", 8'h18, aux_ctrl);
    wr(AUX_DEF_ADR, 8'h04);
    for (int i = 0; i < 2; i++) begin
      reqa_wupa_tx <= (i == 0);
      anticollision_active <= (i == 1);
      repeat (2) @(posedge core_clk);
      chk("crc_auto", 1'b0, aux_ctrl.rx_crc_expected);
      reqa_wupa_tx <= 1'b0;
      anticollision_active <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("crc_back", 1'b1, aux_ctrl.rx_crc_expected);
    end
    analog_preset_am <= 1'b1;
    analog_preset_cmd <= 1'b1;
    @(posedge core_clk);
    analog_preset_cmd <= 1'b0;
    rd("preset", AUX_DEF_ADR, 8'h24);
    wr(AUX_DEF_ADR, 8'h04);
    rd("override", AUX_DEF_ADR, 8'h04);
    $display("test aux done");
    wr(RX_CONF1_ADR, 8'hED);
    rd("rx_rb", RX_CONF1_ADR, 8'hED);
    chk("rx_one", 2'b01, {rx_ctrl.am_channel_enable, rx_ctrl.pm_channel_enable});
    chk("rx_filt", 7'h6D, rx_ctrl[6:0]);
    rx_single_channel <= 1'b0;
    manual_channel_sel <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("rx_manual", 10'h3ED, rx_ctrl);
    manual_channel_sel <= 1'b0;
    auto_channel_pm <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("rx_auto", 10'h36D, rx_ctrl);
    rx_single_channel <= 1'b1;
    wr(RX_CONF1_ADR, 8'h12);
    rd("rx_rb", RX_CONF1_ADR, 8'h12);
    chk("rx_am", 2'b10, {rx_ctrl.am_channel_enable, rx_ctrl.pm_channel_enable});
    $display("test rx done");
    wr(STREAM_MODE_ADR, 8'h7F);
    wr(AUX_DEF_ADR, 8'hFB);
    set_default_cmd <= 1'b1;
    @(posedge core_clk);
    set_default_cmd <= 1'b0;
    rd("stream_def", STREAM_MODE_ADR, 8'h00);
    rd("aux_def", AUX_DEF_ADR, 8'h04);
    rd("rx_def", RX_CONF1_ADR, 8'h00);
    wr(AUX_DEF_ADR, 8'hFB);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd("aux_reset", AUX_DEF_ADR, 8'h04);
    $display("test defaults done");
    print_verdict();
  end
endmodule : tb_top
